/* inc/cif_flag_if.sv */
// set / clear / state of one hardware-cleared flag
interface cif_flag_if;
	logic set_ev;
	logic ack;
	logic wr_en;
	logic wr_val;
	logic state;
	modport ctrl (output set_ev, output ack, output wr_en, output wr_val, input state);
	modport flag (input set_ev, input ack, input wr_en, input wr_val, output state);
endinterface : cif_flag_if

/* inc/cif_pkg.sv */
// Notes on behaviour
// RQ1: the serial-1 / audio receive flag in bit 7 of the first register is set by its event and cleared on vectoring.
// RQ2: the converter-done flag in bit 5 of the first register is set by its event and cleared on vectoring.
// RQ3: the serial-0 receive flag in bit 3 of the first register is set by its event and cleared on vectoring.
// RQ4: the radio done flag in bit 1 of the first register is set by its event and cleared on vectoring.
// RQ5: bits 2 and 0 of the first register reset to one and software always writes one there.
// RQ6: a cipher event sets both cipher flags, bits 1 and 0 of the second register, together.
// RQ7: software writing one to either cipher flag raises a cipher request on its own.
// RQ8: each flag reads one while pending, zero otherwise, and all flags reset to zero.
// RQ9: flags are set by their events whatever the enable bits say.
// RQ10: an enabled pending flag asks the core to vector to its source at the next instruction cycle.
// RQ11: when a module flag is cleared, a still-pending enabled module flag sets the flag again.
// RQ12: unused bits reset to zero and hold written values with no effect on interrupts.
package cif_pkg;
	localparam logic [11:0] OFF_FIRST = 12'h088;
	localparam logic [11:0] OFF_SECOND = 12'h098;
	localparam logic [11:0] OFF_ENABLE = 12'h0A0;
	localparam logic [11:0] OFF_STATUS = 12'h0A4;
	localparam logic [11:0] OFF_MASK = 12'h0A8;
	localparam int BIT_SER1 = 7;
	localparam int BIT_CONV = 5;
	localparam int BIT_SER0 = 3;
	localparam int BIT_RADIO = 1;
	localparam int BIT_CIPH_HI = 1;
	localparam int BIT_CIPH_LO = 0;
	localparam logic [7:0] FIRST_RESET = 8'h05;
	localparam logic [7:0] SECOND_RESET = 8'h00;
	localparam int NSRC = 5;
	// source index: 0 ser1, 1 conv, 2 ser0, 3 radio, 4 cipher
	typedef enum logic [2:0] {
		SRC_SER1,
		SRC_CONV,
		SRC_SER0,
		SRC_RADIO,
		SRC_CIPH
	} cif_src_t;
endpackage : cif_pkg

/* logic/cif_flag.sv */
module cif_flag (
	// system
	input wire logic sys_clk,
	input wire logic rst_n,
	// flag control
	cif_flag_if.flag f
);
	logic state_reg;
	logic state_next;

	// event wins over both ack and a software clear, so nothing is lost
	assign state_next = f.set_ev ? 1'b1 : (f.ack ? 1'b0 : (f.wr_en ? f.wr_val : state_reg));

	// flag storage
	always_ff @(posedge sys_clk) begin
		if (!rst_n) state_reg <= 1'b0;
		else state_reg <= state_next;
	end
	assign f.state = state_reg;

	a_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1 RQ2 RQ3 RQ4
		f.set_ev |=> state_reg) else $error("flag not set by event");
	a_ack_clears: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1 RQ2 RQ3 RQ4
		f.ack && !f.set_ev |=> !state_reg) else $error("flag not cleared by ack");
endmodule : cif_flag

/* logic/cif_flag_regs.sv */
// The APB register port was chosen for this implementation.
module cif_flag_regs (
	// system
	input wire logic sys_clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// peripheral event pulses
	input wire logic ser1_rx_ev,
	input wire logic conv_done_ev,
	input wire logic ser0_rx_ev,
	input wire logic radio_done_ev,
	input wire logic cipher_ev,
	// module flags still pending and enabled, per source
	input wire logic [4:0] module_pending,
	// pulse when a module flag of that source is cleared
	input wire logic [4:0] module_clr,
	// core vectoring
	input wire logic [4:0] vector_ack,
	output logic [4:0] vector_req,
	// interrupt
	output logic irq
);
	logic [7:0] first_reg;
	logic [7:0] first_next;
	logic [7:0] first_view;
	logic [7:0] second_reg;
	logic [7:0] second_next;
	logic [4:0] enable_reg;
	logic [4:0] status_reg;
	logic [4:0] status_next;
	logic [4:0] mask_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rdata_next;
	logic [4:0] flag_state;
	logic [4:0] src_ev;
	logic [4:0] refire;
	logic [4:0] pend;
	logic [4:0] pend_d_reg;
	logic wr_acc;
	logic rd_acc;
	logic sel_first;
	logic sel_second;
	logic sel_enable;
	logic sel_status;
	logic sel_mask;
	logic hit;
	logic wr_first;
	logic wr_second;
	logic cip_hi_next;
	logic cip_lo_next;

	// address decode; pready always high, so every transfer is zero-wait
	assign wr_acc = psel && penable && pwrite && pstrb[0];
	assign rd_acc = psel && !penable && !pwrite;
	assign sel_first = paddr == cif_pkg::OFF_FIRST;
	assign sel_second = paddr == cif_pkg::OFF_SECOND;
	assign sel_enable = paddr == cif_pkg::OFF_ENABLE;
	assign sel_status = paddr == cif_pkg::OFF_STATUS;
	assign sel_mask = paddr == cif_pkg::OFF_MASK;
	assign hit = sel_first | sel_second | sel_enable | sel_status | sel_mask;
	assign wr_first = wr_acc && sel_first;
	assign wr_second = wr_acc && sel_second;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;

	// a module flag cleared while others wait re-raises the cpu flag if its source is enabled
	assign refire = module_clr & module_pending & enable_reg; // RQ11
	// peripherals set flags regardless of enable
	assign src_ev = {cipher_ev, radio_done_ev, ser0_rx_ev, conv_done_ev, ser1_rx_ev} | refire; // RQ9

	// each of the four hardware-cleared flags gets its own instance of the small flag cell
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_hwflag
			localparam int BP = (gi == 0) ? cif_pkg::BIT_SER1 : (gi == 1) ? cif_pkg::BIT_CONV :
				(gi == 2) ? cif_pkg::BIT_SER0 : cif_pkg::BIT_RADIO;
			cif_flag_if fi ();
			assign fi.set_ev = src_ev[gi]; // RQ1 RQ2 RQ3 RQ4
			assign fi.ack = vector_ack[gi]; // RQ1 RQ2 RQ3 RQ4
			assign fi.wr_en = wr_first;
			assign fi.wr_val = pwdata[BP];
			assign flag_state[gi] = fi.state;
			cif_flag u_flag (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.f(fi)
			);
		end
	endgenerate

	// cipher pair: event sets both, software writes each, no hardware clear
	assign cip_hi_next = src_ev[cif_pkg::SRC_CIPH] ? 1'b1 : (wr_second ? pwdata[cif_pkg::BIT_CIPH_HI] : second_reg[cif_pkg::BIT_CIPH_HI]); // RQ6
	assign cip_lo_next = src_ev[cif_pkg::SRC_CIPH] ? 1'b1 : (wr_second ? pwdata[cif_pkg::BIT_CIPH_LO] : second_reg[cif_pkg::BIT_CIPH_LO]); // RQ6
	assign second_next = {(wr_second ? pwdata[7:2] : second_reg[7:2]), cip_hi_next, cip_lo_next}; // RQ12
	// either cipher flag alone keeps the request up
	assign flag_state[4] = second_reg[cif_pkg::BIT_CIPH_HI] | second_reg[cif_pkg::BIT_CIPH_LO]; // RQ7

	// first register: flags from cells, other bits plain storage
	always_comb begin
		first_next = wr_first ? pwdata[7:0] : first_reg; // RQ5 RQ12
		first_next[cif_pkg::BIT_SER1] = flag_state[0];
		first_next[cif_pkg::BIT_CONV] = flag_state[1];
		first_next[cif_pkg::BIT_SER0] = flag_state[2];
		first_next[cif_pkg::BIT_RADIO] = flag_state[3];
	end

	// enabled pending flags request a vector
	assign pend = flag_state & enable_reg;
	assign vector_req = pend; // RQ10

	// new request edges are the sticky events; set wins over write-one-clear
	assign status_next = (pend & ~pend_d_reg) | (status_reg & ~((wr_acc && sel_status) ? pwdata[4:0] : 5'h00));
	assign irq = |(status_reg & mask_reg);

	// read mux; flag bits come live so software sees pending state
	always_comb begin
		rdata_next = 32'h00000000;
		if (sel_first) rdata_next[7:0] = first_next; // RQ8
		else if (sel_second) rdata_next[7:0] = second_reg; // RQ8
		else if (sel_enable) rdata_next[4:0] = enable_reg;
		else if (sel_status) rdata_next[4:0] = status_reg;
		else if (sel_mask) rdata_next[4:0] = mask_reg;
	end
	assign prdata = prdata_reg;

	// register storage
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			second_reg <= cif_pkg::SECOND_RESET; // RQ8
			enable_reg <= 5'h00;
			status_reg <= 5'h00;
			mask_reg <= 5'h00;
			pend_d_reg <= 5'h00;
			prdata_reg <= 32'h00000000;
		end else begin
			second_reg <= second_next;
			status_reg <= status_next;
			pend_d_reg <= pend;
			if (wr_acc && sel_enable) enable_reg <= pwdata[4:0];
			if (wr_acc && sel_mask) mask_reg <= pwdata[4:0];
			if (rd_acc) prdata_reg <= rdata_next;
		end
	end

	// first register storage; reserved ones come up set
	always_ff @(posedge sys_clk) begin
		if (!rst_n) first_reg <= cif_pkg::FIRST_RESET; // RQ5
		else first_reg <= first_next;
	end

	// visible first register: live flag bits over the plain storage bits
	always_comb begin
		first_view = first_reg;
		first_view[cif_pkg::BIT_SER1] = flag_state[0];
		first_view[cif_pkg::BIT_CONV] = flag_state[1];
		first_view[cif_pkg::BIT_SER0] = flag_state[2];
		first_view[cif_pkg::BIT_RADIO] = flag_state[3];
	end

	// core vectors to one source with no fresh event racing the clear
	sequence s_ser1_vectored;
		vector_ack[0] && !src_ev[0];
	endsequence : s_ser1_vectored
	sequence s_conv_vectored;
		vector_ack[1] && !src_ev[1];
	endsequence : s_conv_vectored
	sequence s_ser0_vectored;
		vector_ack[2] && !src_ev[2];
	endsequence : s_ser0_vectored
	sequence s_radio_vectored;
		vector_ack[3] && !src_ev[3];
	endsequence : s_radio_vectored

	// software sets either cipher flag while the cipher source is enabled
	sequence s_cipher_sw_set;
		wr_second && (pwdata[cif_pkg::BIT_CIPH_HI] || pwdata[cif_pkg::BIT_CIPH_LO]) && enable_reg[4];
	endsequence : s_cipher_sw_set

	// a module flag cleared while another enabled one still waits, enable left alone
	sequence s_ser0_refire;
		module_clr[2] && module_pending[2] && enable_reg[2] && !(wr_acc && sel_enable);
	endsequence : s_ser0_refire

	// a converter event on an enabled source, enable left alone
	sequence s_conv_raised;
		conv_done_ev && enable_reg[1] && !(wr_acc && sel_enable);
	endsequence : s_conv_raised

	// first register leaves reset with only the reserved ones set
	a_ser1_reset: assert property (@(posedge sys_clk) // RQ5
		$rose(rst_n) |-> first_view == cif_pkg::FIRST_RESET)
		else $error("first reg reset wrong");

	// second register, requests and interrupt all quiet out of reset
	a_flag_reset: assert property (@(posedge sys_clk) // RQ8
		$rose(rst_n) |-> second_reg == cif_pkg::SECOND_RESET && vector_req == 5'h00 && !irq)
		else $error("flags not clear after reset");

	// serial-1 event shows on the very next edge
	a_ser1_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1 RQ9
		ser1_rx_ev |=> first_view[cif_pkg::BIT_SER1])
		else $error("ser1 flag not set");

	// vectoring drops the serial-1 flag
	a_ser1_ack: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1
		s_ser1_vectored |=> !first_view[cif_pkg::BIT_SER1])
		else $error("ser1 not cleared");

	// converter event shows on the very next edge
	a_conv_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ2
		conv_done_ev |=> first_view[cif_pkg::BIT_CONV])
		else $error("conv flag not set");

	// vectoring drops the converter flag and its request together
	a_conv_ack: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ2
		s_conv_vectored |=> !first_view[cif_pkg::BIT_CONV] && !vector_req[1])
		else $error("conv not cleared");

	// serial-0 event lands even with its enable off
	a_ser0_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ3 RQ9
		ser0_rx_ev && !enable_reg[2] |=> first_view[cif_pkg::BIT_SER0])
		else $error("ser0 flag gated");

	// vectoring drops the serial-0 flag
	a_ser0_ack: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ3
		s_ser0_vectored |=> !first_view[cif_pkg::BIT_SER0])
		else $error("ser0 not cleared");

	// radio event lands even with its enable off
	a_radio_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ4 RQ9
		radio_done_ev && !enable_reg[3] |=> first_view[cif_pkg::BIT_RADIO])
		else $error("radio flag gated");

	// vectoring drops the radio flag
	a_radio_ack: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ4
		s_radio_vectored |=> !first_view[cif_pkg::BIT_RADIO])
		else $error("radio not cleared");

	// plain storage bits of the first register only move on a write
	a_reserved_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ5 RQ12
		!wr_first |=> $stable(first_reg[6]) && $stable(first_reg[4]) && $stable(first_reg[2]) && $stable(first_reg[0]))
		else $error("first reg storage bits moved");

	// one cipher event raises both halves
	a_cipher_both: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ6
		cipher_ev |=> second_reg[1:0] == 2'b11)
		else $error("cipher pair not set");

	// no hardware clear on the cipher pair: it moves only by event or write
	a_cipher_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ6 RQ12
		!wr_second && !src_ev[cif_pkg::SRC_CIPH] |=> $stable(second_reg))
		else $error("second reg moved on its own");

	// one software-set cipher half is enough to request
	a_cipher_swreq: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ7
		s_cipher_sw_set |=> vector_req[4])
		else $error("sw cipher no request");

	// read data stands until the next read setup
	a_read_stands: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ8
		!rd_acc |=> $stable(prdata))
		else $error("read data moved");

	// unmapped reads come back as zero
	a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ12
		rd_acc && !hit |=> prdata == 32'h00000000)
		else $error("unmapped read not zero");

	// an enabled converter event asks the core on the next cycle
	a_vector_req: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
		s_conv_raised |=> vector_req[1])
		else $error("no vector request");

	// a disabled source never asks the core
	a_enable_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
		!enable_reg[2] |-> !vector_req[2])
		else $error("request while disabled");

	// a new request is caught in the sticky status
	a_status_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
		$rose(vector_req[0]) |=> status_reg[0])
		else $error("status not set by request");

	// status stays until software writes a one to it
	a_status_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
		status_reg[1] && !(wr_acc && sel_status && pwdata[1]) |=> status_reg[1])
		else $error("status dropped on its own");

	// with no status pending the interrupt line is low
	a_idle_irq: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
		status_reg == 5'h00 |-> !irq)
		else $error("irq without status");

	// a cleared module flag with another still waiting sets the cpu flag again
	a_refire_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ11
		s_ser0_refire |=> first_view[cif_pkg::BIT_SER0] && vector_req[2])
		else $error("no refire");
endmodule : cif_flag_regs

/* sim/cif_core_model.sv */
module cif_core_model (
	// system
	input wire logic sys_clk,
	input wire logic rst_n,
	// bench control
	input wire logic ack_on,
	input wire logic [3:0] ack_delay,
	// vectoring
	input wire logic [4:0] vector_req,
	output logic [4:0] vector_ack
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] wait_reg;
	logic [4:0] pick;
	// lowest hw-cleared source wins; cipher is left to software, so bit 4 is never answered
	assign pick = vector_req[0] ? 5'h01 : vector_req[1] ? 5'h02 : vector_req[2] ? 5'h04 : vector_req[3] ? 5'h08 : 5'h00;
	// the core answers some cycles later, one source per call, never twice for one request
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !ack_on || pick == 5'h00 || vector_ack != 5'h00) begin
			wait_reg <= 4'h0;
			vector_ack <= 5'h00;
		end else if (wait_reg == ack_delay) begin
			vector_ack <= pick;
			wait_reg <= 4'h0;
		end else begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule : cif_core_model

/* sim/cpu_interrupt_flag_regs_bench.sv */
module cpu_interrupt_flag_regs_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, ack_on, sl;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] ev, module_pending, module_clr, vector_ack, vector_req;
	int err_total, samples_checked;
	cif_flag_regs uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ser1_rx_ev(ev[0]), .conv_done_ev(ev[1]), .ser0_rx_ev(ev[2]), .radio_done_ev(ev[3]), .cipher_ev(ev[4]),
		.module_pending(module_pending), .module_clr(module_clr), .vector_ack(vector_ack),
		.vector_req(vector_req), .irq(irq));
	cif_core_model core (.sys_clk(sys_clk), .rst_n(rst_n), .ack_on(ack_on), .ack_delay(4'h3),
		.vector_req(vector_req), .vector_ack(vector_ack));
	// one compare point so every mismatch is counted the same way
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// apb master: waits for pready, however long the slave takes
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk
	// one-cycle event pulses, one bit per source
	task automatic pulse(input logic [4:0] v);
		ev <= v;
		@(posedge sys_clk);
		ev <= 5'h00;
		@(posedge sys_clk);
	endtask : pulse
	task automatic t_reset;
		rdchk(cif_pkg::OFF_FIRST, 32'h05);
		rdchk(cif_pkg::OFF_SECOND, 32'h00);
		rdchk(cif_pkg::OFF_STATUS, 32'h00);
	endtask : t_reset
	// events land with every enable off, so nothing may be requested
	task automatic t_events;
		pulse(5'h0F);
		rdchk(cif_pkg::OFF_FIRST, 32'hAF);
		pulse(5'h10);
		rdchk(cif_pkg::OFF_SECOND, 32'h03);
		chk({27'h0, vector_req}, 32'h00);
	endtask : t_events
	// enabling lets the core vector to each source in turn, which clears its flag
	task automatic t_vector;
		ack_on <= 1'b1;
		apb(1'b1, cif_pkg::OFF_ENABLE, 32'h0F);
		repeat (30) @(posedge sys_clk);
		rdchk(cif_pkg::OFF_FIRST, 32'h05);
		rdchk(cif_pkg::OFF_STATUS, 32'h0F);
		apb(1'b1, cif_pkg::OFF_STATUS, 32'h0F);
	endtask : t_vector
	// a single software-set cipher flag must raise the request and the interrupt
	task automatic t_cipher;
		apb(1'b1, cif_pkg::OFF_MASK, 32'h10);
		apb(1'b1, cif_pkg::OFF_SECOND, 32'h00);
		apb(1'b1, cif_pkg::OFF_ENABLE, 32'h1F);
		apb(1'b1, cif_pkg::OFF_SECOND, 32'h02);
		chk({31'h0, vector_req[4]}, 32'h1);
		// status latches one edge after the request rises, so irq is looked at one edge later
		@(posedge sys_clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, cif_pkg::OFF_STATUS, 32'h10);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, cif_pkg::OFF_SECOND, 32'hFC);
		rdchk(cif_pkg::OFF_SECOND, 32'hFC);
		chk({31'h0, vector_req[4]}, 32'h0);
	endtask : t_cipher
	// clearing a module flag while another is still pending re-asserts the cpu flag
	task automatic t_rearm;
		ack_on <= 1'b0;
		module_pending <= 5'h04;
		module_clr <= 5'h04;
		@(posedge sys_clk);
		module_clr <= 5'h00;
		@(posedge sys_clk);
		rdchk(cif_pkg::OFF_FIRST, 32'h0D);
		chk({31'h0, vector_req[2]}, 32'h1);
		pulse(5'h02);
		chk({27'h0, vector_req}, 32'h06);
		apb(1'b1, cif_pkg::OFF_FIRST, 32'h05);
		rdchk(cif_pkg::OFF_FIRST, 32'h05);
	endtask : t_rearm
	task automatic t_unmapped;
		rdchk(12'h0FC, 32'h0);
		chk({31'h0, sl}, 32'h1);
	endtask : t_unmapped
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// watchdog well past the hundred or so cycles the scenarios need
	initial begin
		#(50 * 5000);
		err_total++;
		test_done();
	end
	// main sequence
	initial begin
		{rst_n, psel, penable, pwrite, ack_on} = 5'h00;
		{paddr, pwdata, ev, module_pending, module_clr} = '0;
		err_total = 0;
		samples_checked = 0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		t_events();
		t_vector();
		t_cipher();
		t_rearm();
		t_unmapped();
		test_done();
	end
endmodule : cpu_interrupt_flag_regs_bench
